//--- ccp_pwm_pkg.sv
package ccp_pwm_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] OFF_MODE   = 8'h00;
    localparam logic [7:0] OFF_DUTYH  = 8'h04;
    localparam logic [7:0] OFF_SHADOW = 8'h08;
    localparam logic [7:0] OFF_LIMIT  = 8'h0c;
    localparam logic [7:0] OFF_COUNT  = 8'h10;
    localparam logic [7:0] OFF_TCTRL  = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_PINDIR = 8'h1c;
    // Register index encoding
    localparam int        IDX_W      = 4;
    localparam logic [3:0] IDX_MODE   = 4'h0;
    localparam logic [3:0] IDX_DUTYH  = 4'h1;
    localparam logic [3:0] IDX_SHADOW = 4'h2;
    localparam logic [3:0] IDX_LIMIT  = 4'h3;
    localparam logic [3:0] IDX_COUNT  = 4'h4;
    localparam logic [3:0] IDX_TCTRL  = 4'h5;
    localparam logic [3:0] IDX_STATUS = 4'h6;
    localparam logic [3:0] IDX_PINDIR = 4'h7;
    localparam logic [3:0] IDX_NONE   = 4'hf;
    // Field positions
    localparam int DLOW_LSB  = 4;
    localparam int RUN_BIT   = 2;
    localparam int POST_LSB  = 3;
    localparam int PMF_BIT   = 0;
    localparam int KIND_LSB  = 4;
    // Reset values
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] RST_LIMIT  = 8'hff;
    localparam logic       RST_PINDIR = 1'b1;
    // Mode field codes
    localparam logic [3:0] MODE_OFF   = 4'h0;
    localparam logic [3:0] MODE_TOGG  = 4'h2;
    localparam logic [3:0] MODE_SET   = 4'h8;
    localparam logic [3:0] MODE_CLR   = 4'h9;
    localparam logic [3:0] MODE_SWINT = 4'ha;
    localparam logic [3:0] MODE_TRIG  = 4'hb;
    localparam logic [1:0] MODE_PWMHI = 2'h3;
    localparam logic [1:0] MODE_CAPHI = 2'h1;
    // Prescale select codes
    localparam logic [1:0] PS_DIV1    = 2'h0;
    localparam logic [1:0] PS_DIV4    = 2'h1;
    // Timing: four system clocks per counter step at 1:1
    localparam int         PRESC_W    = 6;
    typedef enum logic [2:0] {
        MK_OFF, MK_RESERVED, MK_COMPARE, MK_CAPTURE,
        MK_SWINT, MK_TRIGGER, MK_PWM
    } mode_kind_t;
endpackage

//--- ccp_standard_pwm.sv
`timescale 1ns/10ps
// Function
// - Counter equal to period limit clears on next step, new period.
// - Output goes high at period start unless buffered duty is zero.
// - At boundary, duty high goes to shadow, low bits to latch.
// - Duty is ten bits: duty high register plus control bits 5:4.
// - Duty writes accepted anytime, effective only from next boundary.
// - Shadow register is read-only to software in PWM mode.
// - Shadow plus two-bit latch double-buffer the duty, no glitches.
// - Time base is counter plus clock phase or prescaler bits.
// - Time base equal to shadow and latch drives output low.
// - Period is (limit+1) x 4 clocks x prescale.
// - Postscaler has no effect on the PWM period.
// - Duty beyond period never clears the output that period.
// - Prescaler divides by 1, 4 or 16.
// - Sleep freezes counter, state and output; resume on wake.
// - Reset restores all registers and puts pin in input mode.
// - Mode 0000 off and reset, 11xx PWM, 0001/0011 reserved.
// - Modes 0100 to 0111 select the four capture kinds.
// - Modes 0010, 1000, 1001 select compare toggle, set, clear.
// - Mode 1010 software interrupt, 1011 special event trigger.
// - Clearing the control register releases the output pin.
module ccp_standard_pwm (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Power management
    input  wire logic        sleep,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Output pin
    output logic             pwmOut,
    output logic             pwmOe
);
    import ccp_pwm_pkg::*;

    // Software visible state
    logic [7:0]         modeCtrl;
    logic [7:0]         dutyHigh;
    logic [7:0]         dutyShadow;
    logic [1:0]         dutyLatch;
    logic [7:0]         periodLimit;
    logic [7:0]         periodCounter;
    logic [6:0]         timerCtrl;
    logic               periodMatchFlag;
    logic               pinDir;
    // Time base internals
    logic [PRESC_W-1:0] prescCnt;
    logic [1:0]         lowBits;
    logic [7:0]         countAhead;
    logic [5:0]         stepMask;
    logic               running;
    logic               step;
    logic               boundary;
    logic               pwmMode;
    logic               match;
    logic [9:0]         dutyNext;
    mode_kind_t         modeKind;
    // Bus decode
    logic [IDX_W-1:0]   idx;
    logic               wrEn;
    logic               rdSetup;
    logic [31:0]        next_prdata;

    // Byte address to register index, used for both directions
    function automatic logic [IDX_W-1:0] regIndex(input logic [7:0] a);
        case (a)
            OFF_MODE:   regIndex = IDX_MODE;
            OFF_DUTYH:  regIndex = IDX_DUTYH;
            OFF_SHADOW: regIndex = IDX_SHADOW;
            OFF_LIMIT:  regIndex = IDX_LIMIT;
            OFF_COUNT:  regIndex = IDX_COUNT;
            OFF_TCTRL:  regIndex = IDX_TCTRL;
            OFF_STATUS: regIndex = IDX_STATUS;
            OFF_PINDIR: regIndex = IDX_PINDIR;
            default:    regIndex = IDX_NONE;
        endcase
    endfunction

    // Prescaler bits that extend the counter into a ten-bit base
    function automatic logic [1:0] phaseBits(
        input logic [PRESC_W-1:0] cnt,
        input logic [1:0]         sel
    );
        if (sel == PS_DIV1) begin
            phaseBits = cnt[1:0];
        end else if (sel == PS_DIV4) begin
            phaseBits = cnt[3:2];
        end else begin
            phaseBits = cnt[5:4];
        end
    endfunction

    // Mode field decode; only PWM has a datapath in this block
    always_comb begin
        case (modeCtrl[3:0])
            MODE_OFF:   modeKind = MK_OFF;
            MODE_TOGG:  modeKind = MK_COMPARE;
            MODE_SET:   modeKind = MK_COMPARE;
            MODE_CLR:   modeKind = MK_COMPARE;
            MODE_SWINT: modeKind = MK_SWINT;
            MODE_TRIG:  modeKind = MK_TRIGGER;
            default: begin
                if (modeCtrl[3:2] == MODE_PWMHI) begin
                    modeKind = MK_PWM;
                end else if (modeCtrl[3:2] == MODE_CAPHI) begin
                    modeKind = MK_CAPTURE;
                end else begin
                    modeKind = MK_RESERVED;
                end
            end
        endcase
    end

    assign pwmMode = (modeKind == MK_PWM);

    // Bus strobes: the slave answers in the first access cycle
    assign idx     = regIndex(paddr);
    assign wrEn    = psel && penable && pready && pwrite;
    assign rdSetup = psel && !penable;

    // Step every 4 x prescale clocks; postscaler bits never enter here
    always_comb begin
        if (timerCtrl[1:0] == PS_DIV1) begin
            stepMask = 6'h03;
        end else if (timerCtrl[1:0] == PS_DIV4) begin
            stepMask = 6'h0f;
        end else begin
            stepMask = 6'h3f;
        end
    end

    assign running  = timerCtrl[RUN_BIT] && !sleep;
    assign step     = running && ((prescCnt & stepMask) == stepMask);
    assign boundary = step && (periodCounter == periodLimit);
    // Look one clock ahead: the pin is a flop, so deciding on the current
    // base would hold it high one clock too long for every duty value
    assign lowBits  = phaseBits(PRESC_W'(prescCnt + 1'b1),
                                timerCtrl[1:0]);
    assign countAhead = boundary ? RST_BYTE :
                        step ? periodCounter + 8'h01 : periodCounter;
    // Ten-bit duty from duty high and control bits 5:4
    assign dutyNext = {dutyHigh, modeCtrl[DLOW_LSB +: 2]};
    // Compare against the buffered copy, never the live registers
    assign match    = pwmMode && running &&
                      ({countAhead, lowBits} ==
                       {dutyShadow, dutyLatch});

    // Prescaler; restarts on timer control writes so steps stay whole
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prescCnt <= '0;
        end else if (wrEn && idx == IDX_TCTRL) begin
            prescCnt <= '0;
        end else if (running) begin
            prescCnt <= prescCnt + 1'b1;
        end
    end

    // Period counter; software writes win over counting
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            periodCounter <= RST_BYTE;
        end else if (wrEn && idx == IDX_COUNT) begin
            periodCounter <= pwdata[7:0];
        end else if (boundary) begin
            periodCounter <= RST_BYTE;
        end else if (step) begin
            periodCounter <= periodCounter + 1'b1;
        end
    end

    // Control and duty registers, taken at any time
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            modeCtrl    <= RST_BYTE;
            dutyHigh    <= RST_BYTE;
            periodLimit <= RST_LIMIT;
            timerCtrl   <= '0;
            pinDir      <= RST_PINDIR;
        end else if (wrEn) begin
            case (idx)
                IDX_MODE:   modeCtrl    <= {2'h0, pwdata[5:0]};
                IDX_DUTYH:  dutyHigh    <= pwdata[7:0];
                IDX_LIMIT:  periodLimit <= pwdata[7:0];
                IDX_TCTRL:  timerCtrl   <= pwdata[6:0];
                IDX_PINDIR: pinDir      <= pwdata[0];
                default:    pinDir      <= pinDir;
            endcase
        end
    end

    // Duty buffer: loads at each boundary in PWM mode, frozen in sleep by step
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dutyShadow <= RST_BYTE;
            dutyLatch  <= '0;
        end else if (modeKind == MK_OFF) begin
            dutyShadow <= RST_BYTE;
            dutyLatch  <= '0;
        end else if (pwmMode && boundary) begin
            dutyShadow <= dutyHigh;
            dutyLatch  <= modeCtrl[DLOW_LSB +: 2];
        end else if (!pwmMode && wrEn && idx == IDX_SHADOW) begin
            dutyShadow <= pwdata[7:0];
        end
    end

    // Pin level: set at boundary, clear on match; set wins if both
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pwmOut <= 1'b0;
        end else if (!pwmMode) begin
            pwmOut <= 1'b0;
        end else if (boundary) begin
            pwmOut <= (dutyNext != 10'h000);
        end else if (match) begin
            pwmOut <= 1'b0;
        end
    end

    // Driver enable: PWM mode and direction bit cleared by software
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pwmOe <= 1'b0;
        end else begin
            pwmOe <= pwmMode && !pinDir;
        end
    end

    // Period match flag: write one to clear, a new match wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            periodMatchFlag <= 1'b0;
        end else if (boundary) begin
            periodMatchFlag <= 1'b1;
        end else if (wrEn && idx == IDX_STATUS && pwdata[PMF_BIT]) begin
            periodMatchFlag <= 1'b0;
        end
    end

    // Read data mux, sampled in the setup cycle
    always_comb begin
        next_prdata = '0;
        case (idx)
            IDX_MODE:   next_prdata[7:0] = modeCtrl;
            IDX_DUTYH:  next_prdata[7:0] = dutyHigh;
            IDX_SHADOW: next_prdata[7:0] = dutyShadow;
            IDX_LIMIT:  next_prdata[7:0] = periodLimit;
            IDX_COUNT:  next_prdata[7:0] = periodCounter;
            IDX_TCTRL:  next_prdata[6:0] = timerCtrl;
            IDX_STATUS: begin
                next_prdata[PMF_BIT] = periodMatchFlag;
                next_prdata[KIND_LSB +: 3] = modeKind;
            end
            IDX_PINDIR: next_prdata[0] = pinDir;
            default:    next_prdata = '0;
        endcase
    end

    // APB answer: ready in the first access cycle, error if unmapped
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= rdSetup;
            pslverr <= rdSetup && (idx == IDX_NONE);
            if (rdSetup && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    // Checks on the time base and pin
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Named steps, each used by a single check
    sequence stepGap;
        (!step) [*3];
    endsequence

    sequence shadowWrite;
        wrEn && idx == IDX_SHADOW && pwmMode && !boundary;
    endsequence

    sequence periodEnd;
        boundary && !(wrEn && idx == IDX_COUNT);
    endsequence

    // Time base: wrap, step spacing and freeze
    counter_wrap_a: assert property (
        periodEnd |=> periodCounter == RST_BYTE)
        else $error("counter did not clear after limit");
    flag_on_wrap_a: assert property (
        boundary |=> periodMatchFlag)
        else $error("period flag not set at wrap");
    flag_clear_a: assert property (
        wrEn && idx == IDX_STATUS && pwdata[PMF_BIT] && !boundary
        |=> !periodMatchFlag)
        else $error("period flag not cleared by write");
    step_min_a: assert property (step |=> stepGap)
        else $error("counter steps closer than four clocks");
    count_step_a: assert property (
        step && !boundary && !(wrEn && idx == IDX_COUNT)
        |=> periodCounter == $past(periodCounter) + 8'h01)
        else $error("counter did not advance on a step");
    presc_freeze_a: assert property (
        sleep && !(wrEn && idx == IDX_TCTRL) |=> $stable(prescCnt))
        else $error("prescaler moved during sleep");
    sleep_freeze_a: assert property (
        sleep && !wrEn |=> $stable(periodCounter) && $stable(pwmOut))
        else $error("state moved during sleep");

    // Duty buffer: boundary load, hold in between, cleared when off
    // A mid-period write must never reach the compare
    shadow_load_a: assert property (
        pwmMode && boundary ##1 pwmMode
        |-> dutyShadow == $past(dutyHigh)
            && dutyLatch == $past(modeCtrl[DLOW_LSB +: 2]))
        else $error("duty not latched at boundary");
    duty_hold_a: assert property (
        pwmMode && !boundary |=> $stable(dutyShadow) && $stable(dutyLatch))
        else $error("duty buffer moved inside a period");
    shadow_readonly_a: assert property (
        shadowWrite ##1 pwmMode |-> $stable(dutyShadow))
        else $error("shadow changed by write in PWM mode");
    shadow_open_a: assert property (
        wrEn && idx == IDX_SHADOW && !pwmMode && modeKind != MK_OFF
        |=> dutyShadow == $past(pwdata[7:0]))
        else $error("shadow write lost outside PWM mode");
    off_clears_a: assert property (
        modeKind == MK_OFF |=> dutyShadow == RST_BYTE && dutyLatch == 2'b00)
        else $error("off mode left the duty buffer loaded");

    // Pin: set only at a boundary, cleared on match, idle outside PWM
    set_at_start_a: assert property (
        pwmMode && boundary && dutyNext != 10'h000 ##1 pwmMode |-> pwmOut)
        else $error("output not set at period start");
    zero_duty_a: assert property (
        boundary && dutyNext == 10'h000 |=> !pwmOut)
        else $error("output set with zero duty");
    rise_at_start_a: assert property (
        !boundary |=> !$rose(pwmOut))
        else $error("output rose away from a boundary");
    match_clear_a: assert property (
        match && !boundary |=> !pwmOut)
        else $error("output not cleared on duty match");
    long_duty_a: assert property (
        pwmMode && pwmOut && !boundary
        && periodCounter <= periodLimit
        && {dutyShadow, dutyLatch} > {periodLimit, 2'b11} |=> pwmOut)
        else $error("output cleared with duty beyond period");
    low_outside_a: assert property (
        !pwmMode |=> !pwmOut)
        else $error("output high outside PWM mode");
    pin_release_a: assert property (!pwmMode |=> !pwmOe)
        else $error("pin driven outside PWM mode");
    pin_follow_a: assert property (
        pwmMode && !pinDir |=> pwmOe)
        else $error("driver not enabled in PWM mode");
endmodule // ccp_standard_pwm

//--- pwm_load_model.sv
`timescale 1ns/10ps
// Load on the pin with a pull-down, measuring pulses inside a window
module pwm_load_model (
    // Clock
    input  wire logic        mclk,
    // Pin
    input  wire logic        pwmOut,
    input  wire logic        pwmOe,
    // Measurement window
    input  wire logic        measure,
    output logic [15:0]      highCnt,
    output logic [15:0]      riseCnt
);
    logic level;
    logic prevLevel;

    // A released pin reads low, never the last driven value
    assign level = pwmOe ? pwmOut : 1'b0;

    // Counts clear while the window is shut, so each window starts clean
    always_ff @(posedge mclk) begin
        prevLevel <= level;
        if (!measure) begin
            highCnt <= 16'h0000;
            riseCnt <= 16'h0000;
        end else begin
            highCnt <= highCnt + 16'(level);
            riseCnt <= riseCnt + 16'(level && !prevLevel);
        end
    end
endmodule // pwm_load_model

//--- ccp_standard_pwm_tb.sv
`timescale 1ns/10ps
module ccp_standard_pwm_tb;
    import ccp_pwm_pkg::*;
    logic        mclk, rst, sleep, psel, penable, pwrite, measure;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, pwmOut, pwmOe;
    logic [15:0] highCnt, riseCnt;
    int          errorCnt, checked;
    logic [7:0]  offs [8] = '{OFF_MODE, OFF_DUTYH, OFF_SHADOW, OFF_LIMIT,
                              OFF_COUNT, OFF_TCTRL, OFF_STATUS, OFF_PINDIR};
    logic [7:0]  rstv [8] = '{RST_BYTE, RST_BYTE, RST_BYTE, RST_LIMIT,
                              RST_BYTE, RST_BYTE, RST_BYTE, 8'h01};

    ccp_standard_pwm dut (.mclk(mclk), .rst(rst), .sleep(sleep),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwmOut(pwmOut), .pwmOe(pwmOe));
    pwm_load_model load (.mclk(mclk), .pwmOut(pwmOut), .pwmOe(pwmOe),
        .measure(measure), .highCnt(highCnt), .riseCnt(riseCnt));

    // 250 MHz system clock
    always #2 mclk = ~mclk;

    task automatic tally_and_finish;
        if (errorCnt == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
        paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errorCnt++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask

    // Settle, then measure the pin over w clocks
    task automatic window(input int s, input int w, output logic [15:0] hc,
                          output logic [15:0] rc);
        repeat (s) @(posedge mclk);
        measure <= 1'b1;
        repeat (w) @(posedge mclk);
        measure <= 1'b0;
        @(posedge mclk);
        hc = highCnt;
        rc = riseCnt;
    endtask

    // Mode class as software sees it in the status register
    function automatic logic [2:0] kind_of(input logic [3:0] m);
        if (m == 4'h0) return 3'h0;
        if (m[3:2] == 2'b11) return 3'h6;
        if (m == 4'h1 || m == 4'h3) return 3'h1;
        if (m[3:2] == 2'b01) return 3'h3;
        if (m == 4'ha) return 3'h4;
        if (m == 4'hb) return 3'h5;
        return 3'h2;
    endfunction

    // Watchdog: all scenarios fit well inside this span
    initial begin
        repeat (30000) @(posedge mclk);
        errorCnt++;
        tally_and_finish;
    end

    initial begin
        int          i, ps;
        logic [31:0] q, q1;
        logic        e;
        logic [15:0] hc, rc;
        mclk = 1'b0; rst = 1'b1; sleep = 1'b0; psel = 1'b0;
        penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        measure = 1'b0; errorCnt = 0; checked = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("pin enable after reset", pwmOe, 1'b0);
        for (i = 0; i < 8; i++) begin
            rd(offs[i], q);
            chk("reset value", q, rstv[i]);
        end
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk("unmapped error", e, 1'b1);
        wr(OFF_MODE, 32'hff);
        rd(OFF_MODE, q);
        chk("mode readback", q, 32'h3f);
        // Every mode code: class readback and pin ownership
        wr(OFF_PINDIR, 32'h0);
        wr(OFF_LIMIT, 32'h3);
        wr(OFF_DUTYH, 32'h1);
        wr(OFF_TCTRL, 32'h4);
        for (i = 0; i < 16; i++) begin
            wr(OFF_MODE, i);
            repeat (2) @(posedge mclk);
            rd(OFF_STATUS, q);
            chk("kind", q[6:4], kind_of(i));
            if (i < 12) chk("pin idle", {pwmOe, pwmOut}, 2'b00);
            else chk("pin driven", pwmOe, 1'b1);
        end
        // Start-up order for a whole first pulse
        wr(OFF_PINDIR, 32'h1);
        wr(OFF_MODE, 32'h0);
        wr(OFF_LIMIT, 32'h3);
        wr(OFF_MODE, 32'h2c);
        wr(OFF_DUTYH, 32'h1);
        wr(OFF_STATUS, 32'h1);
        wr(OFF_TCTRL, 32'h4);
        i = 0;
        do begin
            rd(OFF_STATUS, q);
            i++;
        end while (q[0] !== 1'b1 && i < 20);
        chk("period flag", q[0], 1'b1);
        wr(OFF_PINDIR, 32'h0);
        // Duty 6 at limit 3, every prescale code, postscale set
        for (i = 0; i < 4; i++) begin
            ps = (i == 0) ? 1 : (i == 1) ? 4 : 16;
            wr(OFF_TCTRL, 32'h4c | i);
            window(20 * ps, 32 * ps, hc, rc);
            chk("high time", hc, 12 * ps);
            chk("pulses", rc, 2);
        end
        wr(OFF_SHADOW, 32'h55);
        rd(OFF_SHADOW, q);
        chk("shadow", q, 32'h1);
        wr(OFF_TCTRL, 32'h4);
        wr(OFF_DUTYH, 32'h2);
        window(0, 32, hc, rc);
        chk("pulses on change", rc, 2);
        window(0, 32, hc, rc);
        chk("new high time", hc, 20);
        wr(OFF_MODE, 32'h1c);
        window(40, 32, hc, rc);
        chk("low bits", hc, 18);
        wr(OFF_DUTYH, 32'h0);
        wr(OFF_MODE, 32'h0c);
        window(40, 32, hc, rc);
        chk("zero duty", {hc, rc}, 32'h0);
        wr(OFF_DUTYH, 32'hff);
        wr(OFF_MODE, 32'h3c);
        window(40, 32, hc, rc);
        chk("long duty", {hc, rc}, {16'd32, 16'd0});
        wr(OFF_DUTYH, 32'h1);
        wr(OFF_MODE, 32'h2c);
        repeat (40) @(posedge mclk);
        sleep <= 1'b1;
        rd(OFF_COUNT, q1);
        chk("count in range", q1 <= 32'h3, 1'b1);
        window(0, 64, hc, rc);
        rd(OFF_COUNT, q);
        chk("frozen count", q, q1);
        chk("held level", rc == 0 && (hc == 0 || hc == 64), 1'b1);
        sleep <= 1'b0;
        window(40, 32, hc, rc);
        chk("resumed", hc, 12);
        wr(OFF_MODE, 32'h0);
        repeat (2) @(posedge mclk);
        chk("released pin", {pwmOe, pwmOut}, 2'b00);
        rd(OFF_SHADOW, q);
        chk("off clears", q, 32'h0);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(OFF_LIMIT, q);
        chk("limit after reset", q, RST_LIMIT);
        rd(OFF_PINDIR, q);
        chk("direction after reset", q, 32'h1);
        tally_and_finish;
    end
endmodule // ccp_standard_pwm_tb
